// [switch_regs_map.vh]
// Register map, field positions, reset values and timing counts of the
// switch table command registers. Definitions only; included by name.
`ifndef SWITCH_REGS_MAP_VH
`define SWITCH_REGS_MAP_VH

// ----------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_LOOKUP_STATUS 16'h1808
`define IDX_LOOKUP_CONFIG 16'h1809
`define IDX_TAG_COMMAND 16'h180b
`define IDX_TAG_WRITE_DATA 16'h180c
`define IDX_TAG_READ_DATA 16'h1810
`define IDX_TAG_CMD_STATUS 16'h1811

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define STS_MAKE_BIT 0
`define STS_INIT_BIT 1
`define CFG_AGE_TEST_BIT 0
`define CMD_DIR_BIT 5
`define CMD_SEL_BIT 4
`define CMD_IDX_MSB 3
`define CMD_IDX_LSB 0
`define CMD_MSB 5
`define TAG_PEND_BIT 0
`define MEMBER_MSB 17
`define DEFTAG_MSB 14

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CMD_RESET 6'h00
`define WDATA_RESET 18'h00000
`define RDATA_RESET 18'h00000

// ----------------------------------------------------------------------
// Table geometry
// ----------------------------------------------------------------------
`define MEMBER_DEPTH 16
`define DEFTAG_DEPTH 3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ 13'd200
`define INIT_TIME_US 13'd20
`define INIT_CYCLES (`INIT_TIME_US * `CLK_MHZ)
`define CLK_HZ 36'd200000000
`define SEC_PER_MIN 36'd60
`define MS_PER_SEC 36'd1000
`define AGE_NORMAL_MIN 36'd5
`define AGE_TEST_MS 36'd50
`define AGE_NORMAL_CYCLES (`AGE_NORMAL_MIN * `SEC_PER_MIN * `CLK_HZ)
`define AGE_TEST_CYCLES (`AGE_TEST_MS * `CLK_HZ / `MS_PER_SEC)

`endif

// [switch_table_command_props.sv]
// Concurrent checks on the ports of the switch table command registers.
// Assumes one clock CLK and asynchronous active-low RESETN; bound below.
`timescale 1ns/1ps
module switch_table_command_props #(
   parameter [12:0] INIT_CYCLES = 13'd8,
   parameter [35:0] AGE_NORMAL_CYCLES = 36'd50,
   parameter [35:0] AGE_TEST_CYCLES = 36'd10
) (
   input wire CLK,
   input wire RESETN,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [15:0] PADDR,
   input wire [31:0] PWDATA,
   input wire [3:0] PSTRB,
   input wire PREADY,
   input wire [31:0] PRDATA,
   input wire PSLVERR,
   input wire MAKE_START,
   input wire MAKE_DONE,
   input wire RX_DROP,
   input wire AGE_TEST,
   input wire AGE_TICK
);
   reg [15:0] since_reset_reg;
   wire setup = PSEL && !PENABLE;
   wire cfg_wr = PSEL && PENABLE && PWRITE && PADDR == 16'h6024;
   wire mapped = PADDR == 16'h6020 || PADDR == 16'h6024 || PADDR == 16'h602c
      || PADDR == 16'h6030 || PADDR == 16'h6040 || PADDR == 16'h6044;
   // ----------------------------------------
   // Edges since reset release, saturating
   // ----------------------------------------
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         since_reset_reg <= 16'h0000;
      end else if (since_reset_reg != 16'hffff) begin
         since_reset_reg <= since_reset_reg + 16'h0001;
      end
   end
   default clocking dcb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   // One cycle of slack either side of the init edge; exact edge is design-chosen
   init_drop_a: assert property (since_reset_reg < INIT_CYCLES - 13'd1 |-> RX_DROP)
      else $error("packets accepted during init");
   init_done_a: assert property (since_reset_reg > INIT_CYCLES |-> !RX_DROP)
      else $error("init never completed");
   age_follow_a: assert property (cfg_wr && PSTRB[0] |=> AGE_TEST == $past(PWDATA[0]))
      else $error("aging test bit not written");
   age_hold_a: assert property (!cfg_wr |=> $stable(AGE_TEST))
      else $error("aging test bit changed without write");
   tick_pulse_a: assert property (AGE_TICK |=> !AGE_TICK)
      else $error("aging tick longer than a cycle");
   tick_gap_a: assert property (AGE_TICK && AGE_TEST |=> !AGE_TICK [*8])
      else $error("test aging period too short");
   tick_soon_a: assert property ($rose(AGE_TEST) |-> ##[0:11] AGE_TICK)
      else $error("test aging period too long");
   bad_addr_a: assert property (setup && !mapped |=> PSLVERR && PRDATA == 32'h00000000)
      else $error("unmapped access not refused");
   write_data_a: assert property (setup && PWRITE |=> PRDATA == 32'h00000000)
      else $error("read data driven on write");
   zero_wait_a: assert property (PREADY)
      else $error("wait state inserted");
endmodule // switch_table_command_props

bind switch_table_command_regs switch_table_command_props #(.INIT_CYCLES(INIT_CYCLES),
   .AGE_NORMAL_CYCLES(AGE_NORMAL_CYCLES), .AGE_TEST_CYCLES(AGE_TEST_CYCLES)) props_inst (
   .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA),
   .PSLVERR(PSLVERR), .MAKE_START(MAKE_START), .MAKE_DONE(MAKE_DONE), .RX_DROP(RX_DROP),
   .AGE_TEST(AGE_TEST), .AGE_TICK(AGE_TICK));

// [switch_table_command_regs.v]
// Control and status registers of the switch engine: lookup table
// initialisation and entry-creation status, aging timer, and indirect
// commands on the tag membership and per-port default tag tables.
// Assumes an APB master on CLK and an entry-creation engine that pulses
// MAKE_START and MAKE_DONE, both synchronous to CLK.
//
// Functional notes
// - Lookup status bit 1 shows lookup table initialisation is complete.
// - Initialisation runs after every reset of the switch fabric.
// - Initialisation lasts about 20 us.
// - Received packets are dropped while initialisation runs.
// - Init flag reads 0 after reset, self-sets at end, not writable.
// - Lookup status bit 0 shows entry creation busy, self-clears, resets 0.
// - Aging-test bit shortens aging period from 5 min to 50 ms.
// - A write of the tag command register with lane 0 enabled starts a table access unless one is pending.
// - Command bit 5 set means table read, clear means table write.
// - Command bit 4 set picks default tag table, clear membership table.
// - Command bits 3:0 index entry 0-15 or port 0-2.
// - Read: pending stays set until done, then read data register holds result.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "switch_regs_map.vh"
module switch_table_command_regs #(
   parameter [12:0] INIT_CYCLES = `INIT_CYCLES,
   parameter [35:0] AGE_NORMAL_CYCLES = `AGE_NORMAL_CYCLES,
   parameter [35:0] AGE_TEST_CYCLES = `AGE_TEST_CYCLES
) (
   input wire CLK,
   input wire RESETN,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [15:0] PADDR,
   input wire [31:0] PWDATA,
   input wire [3:0] PSTRB,
   output wire PREADY,
   output reg [31:0] PRDATA,
   output reg PSLVERR,
   input wire MAKE_START,
   input wire MAKE_DONE,
   output wire RX_DROP,
   output wire AGE_TEST,
   output reg AGE_TICK
);
   // -------------------------------------------------------------------
   // Addresses and states
   // -------------------------------------------------------------------
   localparam [15:0] A_STATUS = `IDX_LOOKUP_STATUS << 2;
   localparam [15:0] A_CONFIG = `IDX_LOOKUP_CONFIG << 2;
   localparam [15:0] A_CMD = `IDX_TAG_COMMAND << 2;
   localparam [15:0] A_WDATA = `IDX_TAG_WRITE_DATA << 2;
   localparam [15:0] A_RDATA = `IDX_TAG_READ_DATA << 2;
   localparam [15:0] A_CMDSTS = `IDX_TAG_CMD_STATUS << 2;
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_ISSUE = 2'b01;
   localparam [1:0] ST_CAPTURE = 2'b10;
   localparam [12:0] INIT_LAST = INIT_CYCLES - 13'd1;
   localparam MAW = 4;
   localparam DAW = 2;

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   reg [12:0] init_cnt_reg;
   reg init_done_reg;
   reg make_pending_reg;
   reg age_test_reg;
   reg [35:0] age_cnt_reg;
   reg [`CMD_MSB:0] cmd_reg;
   reg [`MEMBER_MSB:0] wdata_reg;
   reg [`MEMBER_MSB:0] op_wdata_reg;
   reg [`MEMBER_MSB:0] rdata_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg pending_reg;
   reg [31:0] rd_mux;
   reg err_next;
   wire setup;
   wire access;
   wire wr_access;
   wire cmd_write;
   wire [35:0] age_limit;
   wire op_read;
   wire op_deftag;
   wire [`CMD_IDX_MSB:0] op_index;
   wire member_wr;
   wire member_rd;
   wire deftag_wr;
   wire deftag_rd;
   wire [`MEMBER_MSB:0] member_q;
   wire [`DEFTAG_MSB:0] deftag_q;

   // -------------------------------------------------------------------
   // APB decode
   // -------------------------------------------------------------------
   // Zero wait states; read data and error are prepared in setup phase
   assign PREADY = 1'b1;
   assign setup = PSEL && !PENABLE;
   assign access = PSEL && PENABLE;
   assign wr_access = access && PWRITE && !PSLVERR;
   // Lane 0 carries every command field, so it must be enabled
   assign cmd_write = wr_access && (PADDR == A_CMD) && PSTRB[0];

   always @* begin
      rd_mux = 32'h00000000;
      err_next = 1'b0;
      case (PADDR)
         A_STATUS: begin
            rd_mux[`STS_INIT_BIT] = init_done_reg;
            rd_mux[`STS_MAKE_BIT] = make_pending_reg;
         end
         A_CONFIG: begin
            rd_mux[`CFG_AGE_TEST_BIT] = age_test_reg;
         end
         A_CMD: begin
            rd_mux[`CMD_MSB:0] = cmd_reg;
            // A new command while one is in flight is refused
            err_next = PWRITE && pending_reg;
         end
         A_WDATA: begin
            rd_mux[`MEMBER_MSB:0] = wdata_reg;
         end
         A_RDATA: begin
            rd_mux[`MEMBER_MSB:0] = rdata_reg;
         end
         A_CMDSTS: begin
            rd_mux[`TAG_PEND_BIT] = pending_reg;
         end
         default: begin
            err_next = 1'b1;
         end
      endcase
   end

   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         PRDATA <= 32'h00000000;
         PSLVERR <= 1'b0;
      end else if (setup) begin
         PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
         PSLVERR <= err_next;
      end
   end

   // -------------------------------------------------------------------
   // Lookup table initialisation
   // -------------------------------------------------------------------
   // Every reset restarts the count, so the flag always reads 0 first
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         init_cnt_reg <= 13'h0000;
         init_done_reg <= 1'b0;
      end else if (!init_done_reg) begin
         if (init_cnt_reg == INIT_LAST) begin
            init_done_reg <= 1'b1;
         end else begin
            init_cnt_reg <= init_cnt_reg + 13'h0001;
         end
      end
   end

   // Writes to lookup registers are not blocked during init
   assign RX_DROP = !init_done_reg;

   // -------------------------------------------------------------------
   // Entry-creation status
   // -------------------------------------------------------------------
   // A start in the same cycle as a done wins, so no command is lost
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         make_pending_reg <= 1'b0;
      end else if (MAKE_START) begin
         make_pending_reg <= 1'b1;
      end else if (MAKE_DONE) begin
         make_pending_reg <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Configuration and aging timer
   // -------------------------------------------------------------------
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         age_test_reg <= 1'b0;
      end else if (wr_access && (PADDR == A_CONFIG) && PSTRB[0]) begin
         age_test_reg <= PWDATA[`CFG_AGE_TEST_BIT];
      end
   end

   assign AGE_TEST = age_test_reg;
   assign age_limit = age_test_reg ? AGE_TEST_CYCLES : AGE_NORMAL_CYCLES;

   // The >= compare lets a switch to test mode end a long period at once
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         age_cnt_reg <= 36'h000000000;
         AGE_TICK <= 1'b0;
      end else if (age_cnt_reg >= age_limit - 36'h000000001) begin
         age_cnt_reg <= 36'h000000000;
         AGE_TICK <= 1'b1;
      end else begin
         age_cnt_reg <= age_cnt_reg + 36'h000000001;
         AGE_TICK <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Tag table command and write data registers
   // -------------------------------------------------------------------
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         wdata_reg <= `WDATA_RESET;
      end else if (wr_access && (PADDR == A_WDATA)) begin
         if (PSTRB[0]) begin
            wdata_reg[7:0] <= PWDATA[7:0];
         end
         if (PSTRB[1]) begin
            wdata_reg[15:8] <= PWDATA[15:8];
         end
         if (PSTRB[2]) begin
            wdata_reg[`MEMBER_MSB:16] <= PWDATA[`MEMBER_MSB:16];
         end
      end
   end

   // Write data is snapshotted with the command, so a later load of the
   // write data register cannot disturb an access in flight
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         cmd_reg <= `CMD_RESET;
         op_wdata_reg <= `WDATA_RESET;
      end else if (cmd_write) begin
         cmd_reg <= PWDATA[`CMD_MSB:0];
         op_wdata_reg <= wdata_reg;
      end
   end

   assign op_read = cmd_reg[`CMD_DIR_BIT];
   assign op_deftag = cmd_reg[`CMD_SEL_BIT];
   assign op_index = cmd_reg[`CMD_IDX_MSB:`CMD_IDX_LSB];

   // -------------------------------------------------------------------
   // Tag table access sequencer
   // -------------------------------------------------------------------
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (cmd_write) begin
               state_next = ST_ISSUE;
            end
         end
         ST_ISSUE: begin
            state_next = ST_CAPTURE;
         end
         ST_CAPTURE: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= ST_IDLE;
         pending_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (cmd_write) begin
            pending_reg <= 1'b1;
         end else if (state_reg == ST_CAPTURE) begin
            pending_reg <= 1'b0;
         end
      end
   end

   // Port index needs only two bits; index 3 falls outside the table
   assign member_wr = (state_reg == ST_ISSUE) && !op_read && !op_deftag;
   assign member_rd = (state_reg == ST_ISSUE) && op_read && !op_deftag;
   assign deftag_wr = (state_reg == ST_ISSUE) && !op_read && op_deftag && !op_index[3];
   assign deftag_rd = (state_reg == ST_ISSUE) && op_read && op_deftag;

   tag_table_ram #(
      .WIDTH(`MEMBER_MSB + 1),
      .DEPTH(`MEMBER_DEPTH),
      .AW(MAW)
   ) member_table (
      .clk(CLK),
      .resetn(RESETN),
      .wr_en(member_wr),
      .rd_en(member_rd),
      .addr(op_index),
      .wdata(op_wdata_reg),
      .rdata(member_q)
   );

   tag_table_ram #(
      .WIDTH(`DEFTAG_MSB + 1),
      .DEPTH(`DEFTAG_DEPTH),
      .AW(DAW)
   ) deftag_table (
      .clk(CLK),
      .resetn(RESETN),
      .wr_en(deftag_wr),
      .rd_en(deftag_rd),
      .addr(op_index[DAW-1:0]),
      .wdata(op_wdata_reg[`DEFTAG_MSB:0]),
      .rdata(deftag_q)
   );

   // Result lands in the same cycle pending drops
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rdata_reg <= `RDATA_RESET;
      end else if ((state_reg == ST_CAPTURE) && op_read) begin
         if (op_deftag) begin
            rdata_reg <= {{(`MEMBER_MSB - `DEFTAG_MSB){1'b0}}, deftag_q};
         end else begin
            rdata_reg <= member_q;
         end
      end
   end
endmodule // switch_table_command_regs

// [tag_table_ram.v]
// Small single-port table memory with registered read data.
// Assumes one access per cycle; out-of-range writes are ignored and out-of-range reads return zero.
`timescale 1ns/1ps
module tag_table_ram #(
   parameter WIDTH = 18,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk,
   input wire resetn,
   input wire wr_en,
   input wire rd_en,
   input wire [AW-1:0] addr,
   input wire [WIDTH-1:0] wdata,
   output reg [WIDTH-1:0] rdata
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   wire in_range;

   assign in_range = ({1'b0, addr} < DEPTH);

   always @(posedge clk) begin
      if (wr_en && in_range) begin
         mem[addr] <= wdata;
      end
   end

   // Out-of-range reads return zero rather than an unknown word
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata <= {WIDTH{1'b0}};
      end else if (rd_en) begin
         rdata <= in_range ? mem[addr] : {WIDTH{1'b0}};
      end
   end
endmodule // tag_table_ram

// [testbench.sv]
// Self-checking bench for the switch table command registers.
// Assumes the register map header is on the include path.
`timescale 1ns/1ps
`include "switch_regs_map.vh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
   $display("BAD %0t got %h exp %h", $time, got, exp); end end
module testbench;
   localparam [15:0] A_STS = `IDX_LOOKUP_STATUS * 4;
   localparam [15:0] A_CFG = `IDX_LOOKUP_CONFIG * 4;
   localparam [15:0] A_CMD = `IDX_TAG_COMMAND * 4;
   localparam [15:0] A_WD = `IDX_TAG_WRITE_DATA * 4;
   localparam [15:0] A_RD = `IDX_TAG_READ_DATA * 4;
   localparam [15:0] A_TST = `IDX_TAG_CMD_STATUS * 4;
   reg CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, MAKE_START = 0, MAKE_DONE = 0;
   reg [15:0] PADDR = 16'h0000;
   reg [31:0] PWDATA = 32'h00000000;
   reg [3:0] PSTRB = 4'h0;
   wire PREADY, PSLVERR, RX_DROP, AGE_TEST, AGE_TICK;
   wire [31:0] PRDATA;
   integer n_errors = 0, comparisons = 0, cycles = 0, i, ticks;
   integer member[0:15];
   integer deftag[0:2];
   reg [31:0] rd, lastw;
   reg err;
   reg [5:0] c;
   always #2.5 CLK = ~CLK;
   // Short counts keep the run brief; expectations follow them
   switch_table_command_regs #(.INIT_CYCLES(13'd8), .AGE_NORMAL_CYCLES(36'd50),
      .AGE_TEST_CYCLES(36'd10)) switch_table_command_regs_inst (
      .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA),
      .PSLVERR(PSLVERR), .MAKE_START(MAKE_START), .MAKE_DONE(MAKE_DONE), .RX_DROP(RX_DROP),
      .AGE_TEST(AGE_TEST), .AGE_TICK(AGE_TICK));
   // ----------------------------------------
   // Closing and hang guard
   // ----------------------------------------
   task complete_run;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, n_errors);
         if (n_errors == 0 && comparisons > 0) begin
            $display("verification passed");
         end else begin
            $display("verification failed");
         end
         $finish;
      end
   endtask
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         complete_run;
      end
   end
   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task apb(input w, input [15:0] a, input [31:0] d, input [3:0] s);
      begin
         @(posedge CLK);
         PSEL <= 1'b1;
         PENABLE <= 1'b0;
         PWRITE <= w;
         PADDR <= a;
         PWDATA <= d;
         PSTRB <= s;
         @(posedge CLK);
         PENABLE <= 1'b1;
         // Only the bench timeout ends a stalled access
         do begin
            @(posedge CLK);
         end while (PREADY !== 1'b1);
         rd = PRDATA;
         err = PSLVERR;
         PSEL <= 1'b0;
         PENABLE <= 1'b0;
      end
   endtask
   task wait_idle;
      integer k;
      begin
         k = 0;
         do begin
            apb(1'b0, A_TST, 32'h0, 4'h0);
            k++;
         end while (rd[0] !== 1'b0 && k < 20);
         `CHK(rd[0], 1'b0)
      end
   endtask
   task cmd(input [5:0] v);
      begin
         apb(1'b1, A_CMD, {26'h0, v}, 4'hf);
         `CHK(err, 1'b0)
         wait_idle;
      end
   endtask
   task check_tables;
      begin
         for (i = 0; i < 19; i++) begin
            c = (i < 16) ? 6'h20 + i[5:0] : 6'h30 + i[5:0] - 6'd16;
            cmd(c);
            apb(1'b0, A_RD, 32'h0, 4'h0);
            `CHK(rd, (i < 16) ? member[i] : deftag[i - 16])
         end
      end
   endtask
   task pulse_make(input done);
      begin
         if (done) MAKE_DONE <= 1'b1; else MAKE_START <= 1'b1;
         @(posedge CLK);
         MAKE_DONE <= 1'b0;
         MAKE_START <= 1'b0;
      end
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      void'($urandom(32'h79fbe529));
      repeat (12) @(posedge CLK);
      RESETN <= 1'b1;
      apb(1'b0, A_STS, 32'h0, 4'h0);
      `CHK(rd, 32'h00000000)
      `CHK(RX_DROP, 1'b1)
      repeat (12) @(posedge CLK);
      apb(1'b1, A_STS, 32'hffffffff, 4'hf);
      apb(1'b0, A_STS, 32'h0, 4'h0);
      `CHK(rd, 32'h00000002)
      `CHK(RX_DROP, 1'b0)
      apb(1'b0, A_CFG, 32'h0, 4'h0);
      `CHK(rd, 32'h00000000)
      apb(1'b0, A_CMD, 32'h0, 4'h0);
      `CHK(rd, 32'h00000000)
      $display("test reset done");
      pulse_make(1'b0);
      apb(1'b0, A_STS, 32'h0, 4'h0);
      `CHK(rd, 32'h00000003)
      pulse_make(1'b1);
      apb(1'b0, A_STS, 32'h0, 4'h0);
      `CHK(rd, 32'h00000002)
      $display("test make_pending done");
      for (i = 0; i < 19; i++) begin
         lastw = $urandom & 32'h0003ffff;
         apb(1'b1, A_WD, lastw, 4'hf);
         apb(1'b0, A_WD, 32'h0, 4'h0);
         `CHK(rd, lastw)
         if (i < 16) member[i] = lastw; else deftag[i - 16] = lastw & 32'h00007fff;
         c = (i < 16) ? i[5:0] : 6'h10 + i[5:0] - 6'd16;
         cmd(c);
      end
      check_tables;
      $display("test tables done");
      // Second command lands while the first is still busy
      apb(1'b1, A_CMD, 32'h00000003, 4'hf);
      apb(1'b1, A_CMD, 32'h00000004, 4'hf);
      `CHK(err, 1'b1)
      member[3] = lastw;
      wait_idle;
      apb(1'b1, A_CMD, 32'h00000005, 4'hf);
      apb(1'b0, A_TST, 32'h0, 4'h0);
      `CHK(rd[0], 1'b1)
      member[5] = lastw;
      wait_idle;
      check_tables;
      $display("test busy done");
      apb(1'b1, A_CFG, 32'h1, 4'h0);
      apb(1'b0, A_CFG, 32'h0, 4'h0);
      `CHK(rd, 32'h00000000)
      apb(1'b1, A_CFG, 32'h1, 4'hf);
      apb(1'b0, A_CFG, 32'h0, 4'h0);
      `CHK(rd, 32'h00000001)
      `CHK(AGE_TEST, 1'b1)
      repeat (12) @(posedge CLK);
      ticks = 0;
      repeat (40) begin
         @(posedge CLK);
         ticks = ticks + AGE_TICK;
      end
      `CHK(ticks, 4)
      apb(1'b1, A_CFG, 32'h0, 4'hf);
      // The bit is launched on the access edge; look one edge later
      @(posedge CLK);
      `CHK(AGE_TEST, 1'b0)
      $display("test aging done");
      apb(1'b0, 16'h6028, 32'h0, 4'h0);
      `CHK({err, rd}, {1'b1, 32'h00000000})
      apb(1'b1, 16'h6028, 32'h0, 4'hf);
      `CHK(err, 1'b1)
      $display("test unmapped done");
      pulse_make(1'b0);
      RESETN <= 1'b0;
      repeat (3) @(posedge CLK);
      `CHK(RX_DROP, 1'b1)
      RESETN <= 1'b1;
      apb(1'b0, A_STS, 32'h0, 4'h0);
      `CHK(rd, 32'h00000000)
      repeat (12) @(posedge CLK);
      apb(1'b0, A_STS, 32'h0, 4'h0);
      `CHK(rd, 32'h00000002)
      $display("test second_reset done");
      complete_run;
   end
endmodule // testbench
